// ### rtl/hrs_consts.svh
// Summary of operation
// - Strobe toggles only in HS400 mode, while device drives
// - Strobe also toggles with every command response in HS400 mode
// - Reset sequence starts on reset line rising edge
// - Host holds reset low, then high, 1 us
// - Host waits 200 us before first command
// - Host gives 74 link clocks before command
// - Reset line ignored until enable setting loaded
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define HRS_CLK_PERIOD_NS 50
`define HRS_RSTW_NS 1000
`define HRS_RSTH_NS 1000
`define HRS_RSCA_NS 200000
`define HRS_RSTW_CYC ((`HRS_RSTW_NS + `HRS_CLK_PERIOD_NS - 1) / `HRS_CLK_PERIOD_NS)
`define HRS_RSTH_CYC ((`HRS_RSTH_NS + `HRS_CLK_PERIOD_NS - 1) / `HRS_CLK_PERIOD_NS)
`define HRS_RSCA_CYC ((`HRS_RSCA_NS + `HRS_CLK_PERIOD_NS - 1) / `HRS_CLK_PERIOD_NS)
`define HRS_INIT_CLKS 74
`define HRS_LINK_HALF 4

// ----------------------------------------
// Framing
// ----------------------------------------
`define HRS_FRAME_BITS 48
`define HRS_TOKEN_BITS 5
`define HRS_DAT_W 8

`endif

// ### rtl/hrs_pkg.sv
package hrs_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_RESP = 2'b01,
		TX_READ = 2'b10,
		TX_CRC  = 2'b11
	} hrs_dev_state_t;

	typedef enum logic [1:0] {
		HS_RUN  = 2'b00,
		HS_LOW  = 2'b01,
		HS_WAIT = 2'b10
	} hrs_host_state_t;
endpackage

// ### rtl/hrs_link_if.sv
interface hrs_link_if;
	logic       link_clk;
	logic       rst_line_n;
	logic       cmd_h_out;
	logic       cmd_h_oe;
	logic       cmd_d_out;
	logic       cmd_d_oe;
	logic       cmd_line;
	logic [7:0] dat_d_out;
	logic       dat_d_oe;
	logic [7:0] dat_line;
	logic       read_strobe_output;

	// Shared command line: host drive wins, then device drive, else pull-up
	assign cmd_line = cmd_h_oe ? cmd_h_out : (cmd_d_oe ? cmd_d_out : 1'b1);
	assign dat_line = dat_d_oe ? dat_d_out : 8'hff;

	modport dev (
		input  link_clk, rst_line_n, cmd_line,
		output cmd_d_out, cmd_d_oe, dat_d_out, dat_d_oe, read_strobe_output
	);
	modport host (
		input  cmd_line, dat_line, read_strobe_output,
		output link_clk, rst_line_n, cmd_h_out, cmd_h_oe
	);
endinterface

// ### rtl/hrs_device.sv
`include "hrs_consts.svh"

module hrs_device
	import hrs_pkg::*;
#(
	parameter int POR_LOAD_CYC = 16,
	parameter int RST_SEQ_CYC  = 8
) (
	input  wire logic              clock_in,
	input  wire logic              rstn_in,
	hrs_link_if.dev                link,
	input  wire logic              hs400_mode_in,
	input  wire logic              rst_func_en_in,
	input  wire logic              resp_start_in,
	input  wire logic [47:0]       resp_bits_in,
	input  wire logic              rd_start_in,
	input  wire logic [7:0]        rd_len_in,
	input  wire logic [7:0]        rd_data_in,
	input  wire logic              crc_start_in,
	input  wire logic [2:0]        crc_tok_in,
	output logic                   rd_take_out,
	output logic                   cmd_valid_out,
	output logic [47:0]            cmd_word_out,
	output logic                   tx_busy_out,
	output logic                   reset_busy_out,
	output logic                   reset_evt_out,
	output logic                   rst_loaded_out
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic lclk_s1_q, lclk_s2_q, lclk_s3_q;
	logic rst_s1_q, rst_s2_q, rst_s3_q;
	logic cmd_s1_q, cmd_s2_q;
	logic lclk_rise, lclk_fall, rst_rise;

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lclk_s1_q <= 1'b0;
			lclk_s2_q <= 1'b0;
			lclk_s3_q <= 1'b0;
			rst_s1_q  <= 1'b1;
			rst_s2_q  <= 1'b1;
			rst_s3_q  <= 1'b1;
			cmd_s1_q  <= 1'b1;
			cmd_s2_q  <= 1'b1;
		end else begin
			lclk_s1_q <= link.link_clk;
			lclk_s2_q <= lclk_s1_q;
			lclk_s3_q <= lclk_s2_q;
			rst_s1_q  <= link.rst_line_n;
			rst_s2_q  <= rst_s1_q;
			rst_s3_q  <= rst_s2_q;
			cmd_s1_q  <= link.cmd_line;
			cmd_s2_q  <= cmd_s1_q;
		end
	end

	assign lclk_rise = lclk_s2_q & ~lclk_s3_q;
	assign lclk_fall = ~lclk_s2_q & lclk_s3_q;
	assign rst_rise  = rst_s2_q & ~rst_s3_q;

	// ----------------------------------------
	// Power-on load and reset sequence
	// ----------------------------------------
	logic [7:0] por_cnt_q, por_cnt_d;
	logic       loaded_q, loaded_d;
	logic       rst_en_q, rst_en_d;
	logic [7:0] seq_cnt_q, seq_cnt_d;
	logic       evt_q, evt_d;
	logic       rbusy_q, rbusy_d;
	logic       seq_busy;

	assign seq_busy = (seq_cnt_q != 8'h00);

	always_comb begin
		por_cnt_d = por_cnt_q;
		loaded_d  = loaded_q;
		rst_en_d  = rst_en_q;
		seq_cnt_d = seq_cnt_q;
		evt_d     = 1'b0;
		if (!loaded_q) begin
			if (por_cnt_q == 8'(POR_LOAD_CYC)) begin
				loaded_d = 1'b1;
				rst_en_d = rst_func_en_in;
			end else begin
				por_cnt_d = por_cnt_q + 8'h01;
			end
		end else if (rst_en_q && rst_rise) begin
			seq_cnt_d = 8'(RST_SEQ_CYC);
			evt_d     = 1'b1;
		end else if (seq_busy) begin
			seq_cnt_d = seq_cnt_q - 8'h01;
		end
		rbusy_d = (seq_cnt_d != 8'h00);
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			por_cnt_q <= 8'h00;
			loaded_q  <= 1'b0;
			rst_en_q  <= 1'b0;
			seq_cnt_q <= 8'h00;
			evt_q     <= 1'b0;
			rbusy_q   <= 1'b0;
		end else begin
			por_cnt_q <= por_cnt_d;
			loaded_q  <= loaded_d;
			rst_en_q  <= rst_en_d;
			seq_cnt_q <= seq_cnt_d;
			evt_q     <= evt_d;
			rbusy_q   <= rbusy_d;
		end
	end

	// ----------------------------------------
	// Command receiver
	// ----------------------------------------
	logic [5:0]  rx_cnt_q, rx_cnt_d;
	logic [47:0] rx_sh_q, rx_sh_d;
	logic        cmd_vld_q, cmd_vld_d;
	logic [47:0] cmd_word_q, cmd_word_d;

	always_comb begin
		rx_cnt_d   = rx_cnt_q;
		rx_sh_d    = rx_sh_q;
		cmd_vld_d  = 1'b0;
		cmd_word_d = cmd_word_q;
		if (seq_busy || !rst_s2_q) begin
			rx_cnt_d = 6'h00;
		end else if (lclk_rise && !link.cmd_d_oe) begin
			if (rx_cnt_q != 6'h00 || !cmd_s2_q) begin
				rx_sh_d = {rx_sh_q[46:0], cmd_s2_q};
				if (rx_cnt_q == 6'(`HRS_FRAME_BITS - 1)) begin
					rx_cnt_d   = 6'h00;
					cmd_vld_d  = 1'b1;
					cmd_word_d = {rx_sh_q[46:0], cmd_s2_q};
				end else begin
					rx_cnt_d = rx_cnt_q + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_cnt_q   <= 6'h00;
			rx_sh_q    <= 48'h0;
			cmd_vld_q  <= 1'b0;
			cmd_word_q <= 48'h0;
		end else begin
			rx_cnt_q   <= rx_cnt_d;
			rx_sh_q    <= rx_sh_d;
			cmd_vld_q  <= cmd_vld_d;
			cmd_word_q <= cmd_word_d;
		end
	end

	// ----------------------------------------
	// Transmitter and strobe
	// ----------------------------------------
	hrs_dev_state_t state_q, state_d;
	logic [5:0]  bit_cnt_q, bit_cnt_d;
	logic [7:0]  byte_cnt_q, byte_cnt_d;
	logic [47:0] sh_q, sh_d;
	logic        cmd_o_q, cmd_o_d, cmd_oe_q, cmd_oe_d;
	logic [7:0]  dat_q, dat_d;
	logic        dat_oe_q, dat_oe_d;
	logic        strobe_q, strobe_d;
	logic        take_q, take_d;
	logic        txb_q, txb_d;

	always_comb begin
		state_d    = state_q;
		bit_cnt_d  = bit_cnt_q;
		byte_cnt_d = byte_cnt_q;
		sh_d       = sh_q;
		cmd_o_d    = cmd_o_q;
		cmd_oe_d   = cmd_oe_q;
		dat_d      = dat_q;
		dat_oe_d   = dat_oe_q;
		take_d     = 1'b0;
		// Strobe idles low outside transfers
		strobe_d   = 1'b0;
		if (seq_busy) begin
			state_d  = TX_IDLE;
			cmd_oe_d = 1'b0;
			dat_oe_d = 1'b0;
		end else begin
			unique case (state_q)
				TX_IDLE: begin
					bit_cnt_d = 6'h00;
					if (resp_start_in) begin
						state_d = TX_RESP;
						sh_d    = resp_bits_in;
					end else if (rd_start_in && rd_len_in != 8'h00) begin
						state_d    = TX_READ;
						byte_cnt_d = rd_len_in;
					end else if (crc_start_in) begin
						state_d = TX_CRC;
						sh_d    = {1'b0, crc_tok_in, 1'b1, 43'h0};
					end
				end
				TX_RESP: begin
					// Only while driving: no edge ahead of first bit
					strobe_d = hs400_mode_in & lclk_s2_q
						& cmd_oe_q;
					if (lclk_fall) begin
						if (bit_cnt_q == 6'(`HRS_FRAME_BITS)) begin
							state_d  = TX_IDLE;
							cmd_oe_d = 1'b0;
						end else begin
							cmd_oe_d  = 1'b1;
							cmd_o_d   = sh_q[47];
							sh_d      = {sh_q[46:0], 1'b1};
							bit_cnt_d = bit_cnt_q + 6'h01;
						end
					end
				end
				TX_READ: begin
					strobe_d = hs400_mode_in & lclk_s2_q
						& dat_oe_q;
					if (lclk_fall) begin
						if (byte_cnt_q == 8'h00) begin
							state_d  = TX_IDLE;
							dat_oe_d = 1'b0;
						end else begin
							dat_oe_d   = 1'b1;
							dat_d      = rd_data_in;
							take_d     = 1'b1;
							byte_cnt_d = byte_cnt_q - 8'h01;
						end
					end
				end
				TX_CRC: begin
					strobe_d = hs400_mode_in & lclk_s2_q
						& dat_oe_q;
					if (lclk_fall) begin
						if (bit_cnt_q == 6'(`HRS_TOKEN_BITS)) begin
							state_d  = TX_IDLE;
							dat_oe_d = 1'b0;
						end else begin
							dat_oe_d  = 1'b1;
							dat_d     = {7'h7f, sh_q[47]};
							sh_d      = {sh_q[46:0], 1'b1};
							bit_cnt_d = bit_cnt_q + 6'h01;
						end
					end
				end
			endcase
		end
		txb_d = (state_d != TX_IDLE);
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_q    <= TX_IDLE;
			bit_cnt_q  <= 6'h00;
			byte_cnt_q <= 8'h00;
			sh_q       <= 48'h0;
			cmd_o_q    <= 1'b1;
			cmd_oe_q   <= 1'b0;
			dat_q      <= 8'hff;
			dat_oe_q   <= 1'b0;
			strobe_q   <= 1'b0;
			take_q     <= 1'b0;
			txb_q      <= 1'b0;
		end else begin
			state_q    <= state_d;
			bit_cnt_q  <= bit_cnt_d;
			byte_cnt_q <= byte_cnt_d;
			sh_q       <= sh_d;
			cmd_o_q    <= cmd_o_d;
			cmd_oe_q   <= cmd_oe_d;
			dat_q      <= dat_d;
			dat_oe_q   <= dat_oe_d;
			strobe_q   <= strobe_d;
			take_q     <= take_d;
			txb_q      <= txb_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign link.cmd_d_out          = cmd_o_q;
	assign link.cmd_d_oe           = cmd_oe_q;
	assign link.dat_d_out          = dat_q;
	assign link.dat_d_oe           = dat_oe_q;
	assign link.read_strobe_output = strobe_q;
	assign rd_take_out             = take_q;
	assign cmd_valid_out           = cmd_vld_q;
	assign cmd_word_out            = cmd_word_q;
	assign tx_busy_out             = txb_q;
	assign reset_busy_out          = rbusy_q;
	assign reset_evt_out           = evt_q;
	assign rst_loaded_out          = loaded_q;

endmodule // hrs_device

// ### rtl/hrs_host.sv
`include "hrs_consts.svh"

module hrs_host
	import hrs_pkg::*;
(
	input  wire logic              clock_in,
	input  wire logic              rstn_in,
	hrs_link_if.host               link,
	input  wire logic              hw_reset_req_in,
	input  wire logic              cmd_start_in,
	input  wire logic [47:0]       cmd_bits_in,
	output logic                   cmd_ready_out,
	output logic                   resp_valid_out,
	output logic [47:0]            resp_word_out,
	output logic                   rd_valid_out,
	output logic [7:0]             rd_byte_out
);

	// ----------------------------------------
	// Link clock divider and reset pacing
	// ----------------------------------------
	hrs_host_state_t st_q, st_d;
	logic [1:0]  div_q, div_d;
	logic        lclk_q, lclk_d;
	logic [11:0] tm_q, tm_d;
	logic [6:0]  nclk_q, nclk_d;
	logic        rst_q, rst_d;
	logic        lfall, lrise;
	logic        tx_act_q, tx_act_d;

	assign lfall = (div_q == 2'(`HRS_LINK_HALF - 1)) & lclk_q;
	assign lrise = (div_q == 2'(`HRS_LINK_HALF - 1)) & ~lclk_q;

	always_comb begin
		div_d  = div_q + 2'h1;
		lclk_d = (div_q == 2'(`HRS_LINK_HALF - 1)) ? ~lclk_q : lclk_q;
		st_d   = st_q;
		tm_d   = tm_q;
		nclk_d = nclk_q;
		rst_d  = rst_q;
		unique case (st_q)
			HS_RUN: begin
				if (hw_reset_req_in && !tx_act_q) begin
					st_d  = HS_LOW;
					rst_d = 1'b0;
					tm_d  = 12'h000;
				end
			end
			HS_LOW: begin
				if (tm_q == 12'(`HRS_RSTW_CYC - 1)) begin
					st_d   = HS_WAIT;
					rst_d  = 1'b1;
					tm_d   = 12'h000;
					nclk_d = 7'h00;
				end else begin
					tm_d = tm_q + 12'h001;
				end
			end
			HS_WAIT: begin
				if (tm_q != 12'(`HRS_RSCA_CYC)) begin
					tm_d = tm_q + 12'h001;
				end
				if (lrise && nclk_q != 7'(`HRS_INIT_CLKS)) begin
					nclk_d = nclk_q + 7'h01;
				end
				if (hw_reset_req_in && tm_q >= 12'(`HRS_RSTH_CYC)) begin
					st_d  = HS_LOW;
					rst_d = 1'b0;
					tm_d  = 12'h000;
				end else if (tm_q == 12'(`HRS_RSCA_CYC)
						&& nclk_q == 7'(`HRS_INIT_CLKS)) begin
					st_d = HS_RUN;
				end
			end
			default: begin
				st_d = HS_WAIT;
			end
		endcase
	end

	// ----------------------------------------
	// Command sender
	// ----------------------------------------
	logic [5:0]  tx_cnt_q, tx_cnt_d;
	logic [47:0] tx_sh_q, tx_sh_d;
	logic        cmd_o_q, cmd_o_d, cmd_oe_q, cmd_oe_d;
	logic        rdy_q, rdy_d;

	always_comb begin
		tx_act_d = tx_act_q;
		tx_cnt_d = tx_cnt_q;
		tx_sh_d  = tx_sh_q;
		cmd_o_d  = cmd_o_q;
		cmd_oe_d = cmd_oe_q;
		if (!tx_act_q) begin
			if (cmd_start_in && rdy_q) begin
				tx_act_d = 1'b1;
				tx_sh_d  = cmd_bits_in;
				tx_cnt_d = 6'h00;
			end
		end else if (lfall) begin
			if (tx_cnt_q == 6'(`HRS_FRAME_BITS)) begin
				tx_act_d = 1'b0;
				cmd_oe_d = 1'b0;
			end else begin
				cmd_oe_d = 1'b1;
				cmd_o_d  = tx_sh_q[47];
				tx_sh_d  = {tx_sh_q[46:0], 1'b1};
				tx_cnt_d = tx_cnt_q + 6'h01;
			end
		end
		rdy_d = (st_d == HS_RUN) & ~tx_act_d & ~hw_reset_req_in;
	end

	// ----------------------------------------
	// Strobe-timed receiver
	// ----------------------------------------
	logic       sb_s1_q, sb_s2_q, sb_s3_q, cm_s1_q, cm_s2_q;
	logic [7:0] dt_s1_q, dt_s2_q;
	logic [5:0]  rx_cnt_q, rx_cnt_d;
	logic [47:0] rx_sh_q, rx_sh_d, resp_q, resp_d;
	logic        rv_q, rv_d, dv_q, dv_d;
	logic [7:0]  rb_q, rb_d;

	always_comb begin
		rx_cnt_d = rx_cnt_q;
		rx_sh_d  = rx_sh_q;
		resp_d   = resp_q;
		rb_d     = rb_q;
		rv_d     = 1'b0;
		dv_d     = 1'b0;
		if (sb_s2_q && !sb_s3_q && !tx_act_q) begin
			if (rx_cnt_q != 6'h00 || !cm_s2_q) begin
				rx_sh_d = {rx_sh_q[46:0], cm_s2_q};
				if (rx_cnt_q == 6'(`HRS_FRAME_BITS - 1)) begin
					rx_cnt_d = 6'h00;
					rv_d     = 1'b1;
					resp_d   = {rx_sh_q[46:0], cm_s2_q};
				end else begin
					rx_cnt_d = rx_cnt_q + 6'h01;
				end
			end else begin
				dv_d = 1'b1;
				rb_d = dt_s2_q;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_q     <= HS_WAIT;
			div_q    <= 2'h0;
			lclk_q   <= 1'b0;
			tm_q     <= 12'h000;
			nclk_q   <= 7'h00;
			rst_q    <= 1'b1;
			tx_act_q <= 1'b0;
			tx_cnt_q <= 6'h00;
			tx_sh_q  <= 48'h0;
			cmd_o_q  <= 1'b1;
			cmd_oe_q <= 1'b0;
			rdy_q    <= 1'b0;
			sb_s1_q  <= 1'b0;
			sb_s2_q  <= 1'b0;
			sb_s3_q  <= 1'b0;
			cm_s1_q  <= 1'b1;
			cm_s2_q  <= 1'b1;
			dt_s1_q  <= 8'hff;
			dt_s2_q  <= 8'hff;
			rx_cnt_q <= 6'h00;
			rx_sh_q  <= 48'h0;
			resp_q   <= 48'h0;
			rv_q     <= 1'b0;
			dv_q     <= 1'b0;
			rb_q     <= 8'h00;
		end else begin
			st_q     <= st_d;
			div_q    <= div_d;
			lclk_q   <= lclk_d;
			tm_q     <= tm_d;
			nclk_q   <= nclk_d;
			rst_q    <= rst_d;
			tx_act_q <= tx_act_d;
			tx_cnt_q <= tx_cnt_d;
			tx_sh_q  <= tx_sh_d;
			cmd_o_q  <= cmd_o_d;
			cmd_oe_q <= cmd_oe_d;
			rdy_q    <= rdy_d;
			sb_s1_q  <= link.read_strobe_output;
			sb_s2_q  <= sb_s1_q;
			sb_s3_q  <= sb_s2_q;
			cm_s1_q  <= link.cmd_line;
			cm_s2_q  <= cm_s1_q;
			dt_s1_q  <= link.dat_line;
			dt_s2_q  <= dt_s1_q;
			rx_cnt_q <= rx_cnt_d;
			rx_sh_q  <= rx_sh_d;
			resp_q   <= resp_d;
			rv_q     <= rv_d;
			dv_q     <= dv_d;
			rb_q     <= rb_d;
		end
	end

	assign link.link_clk   = lclk_q;
	assign link.rst_line_n = rst_q;
	assign link.cmd_h_out  = cmd_o_q;
	assign link.cmd_h_oe   = cmd_oe_q;
	assign cmd_ready_out   = rdy_q;
	assign resp_valid_out  = rv_q;
	assign resp_word_out   = resp_q;
	assign rd_valid_out    = dv_q;
	assign rd_byte_out     = rb_q;

endmodule // hrs_host

// ### tb/hrs_link_asserts.sv
module hrs_link_asserts (
	input  wire logic clock_in,
	input  wire logic rstn_in,
	input  wire logic link_clk,
	input  wire logic rst_line_n,
	input  wire logic cmd_h_oe,
	input  wire logic cmd_d_oe,
	input  wire logic dat_d_oe,
	input  wire logic read_strobe_output,
	input  wire logic hs400_mode_in,
	input  wire logic rst_func_en_in
);
	logic [5:0]  lo_q, lo_d;
	logic [5:0]  hi_q, hi_d;
	logic [12:0] since_q, since_d;
	logic [6:0]  rises_q, rises_d;
	logic        lclk_q;
	wire         dev_oe = cmd_d_oe | dat_d_oe;

	// ----------------
	// Line counters
	// ----------------
	always_comb begin
		lo_d    = rst_line_n ? 6'h00 : lo_q + {5'h00, lo_q != 6'h3f};
		hi_d    = !rst_line_n ? 6'h00 : hi_q + {5'h00, hi_q != 6'h3f};
		since_d = !rst_line_n ? 13'h0000
			: since_q + {12'h000, since_q != 13'h1fff};
		rises_d = !rst_line_n ? 7'h00 : rises_q
			+ {6'h00, link_clk & !lclk_q & (rises_q != 7'h7f)};
	end

	always_ff @(posedge clock_in or negedge rstn_in) begin
		if (!rstn_in) begin
			lo_q    <= 6'h00;
			hi_q    <= 6'h00;
			since_q <= 13'h0000;
			rises_q <= 7'h00;
			lclk_q  <= 1'b0;
		end else begin
			lo_q    <= lo_d;
			hi_q    <= hi_d;
			since_q <= since_d;
			rises_q <= rises_d;
			lclk_q  <= link_clk;
		end
	end

	// ----------------
	// Properties
	// ----------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rstn_in);

	AST_STB_NEAR_XFER: assert property (
		$rose(read_strobe_output) |-> dev_oe)
		else $error("strobe rose outside a transfer");
	AST_STB_OFF_MODE: assert property (
		!hs400_mode_in && $past(hs400_mode_in, 1) == 1'b0
		|-> !read_strobe_output)
		else $error("strobe active outside fast mode");
	AST_STB_WITH_RESP: assert property (
		$rose(cmd_d_oe) && hs400_mode_in
		|-> ##[1:12] $rose(read_strobe_output))
		else $error("response without strobe");
	AST_RST_ABORTS: assert property (
		$rose(rst_line_n) && rst_func_en_in |-> ##6 !dev_oe)
		else $error("device still driving after reset edge");
	AST_RST_LOW_W: assert property (
		$rose(rst_line_n) |-> lo_q == 6'h14)
		else $error("reset pulse width wrong");
	AST_RST_HIGH_W: assert property (
		$fell(rst_line_n) |-> hi_q >= 6'h14)
		else $error("reset pulses too close");
	AST_CMD_WAIT: assert property (
		$rose(cmd_h_oe) |-> since_q >= 13'h0fa0)
		else $error("command too soon after reset");
	AST_CMD_CLKS: assert property (
		$rose(cmd_h_oe) |-> rises_q >= 7'h4a)
		else $error("too few link clocks before command");

	AST_COV_RESP: cover property ($rose(cmd_d_oe));
	AST_COV_READ: cover property ($rose(dat_d_oe));
	AST_COV_RST:  cover property ($rose(rst_line_n));
	AST_COV_CMD:  cover property ($rose(cmd_h_oe));
endmodule // hrs_link_asserts

// ### tb/test_hw_reset_and_strobe_control.sv
module test_hw_reset_and_strobe_control;
	timeunit 1ns;
	timeprecision 1ns;

	logic        clock_in, rstn_in, hw_reset_req, cmd_start, resp_start;
	logic        rd_start, crc_start, hs400_mode, rst_func_en;
	logic [47:0] cmd_bits, resp_bits, cmd_word, resp_word;
	logic [7:0]  rd_len, rd_data, rd_byte;
	logic [2:0]  crc_tok;
	logic        rd_take, cmd_valid, tx_busy, reset_busy, reset_evt;
	logic        rst_loaded, cmd_ready, resp_valid, rd_valid, stb_q;
	logic [31:0] rnd = 32'h3492;
	logic [7:0]  exp_b [5];
	logic [7:0]  rd_q [$];
	int          miscompares, n_compared, n_stb, k, t, s0, idx;

	hrs_link_if link ();

	hrs_host i_hrs_host (
		.clock_in        (clock_in),
		.rstn_in         (rstn_in),
		.link            (link.host),
		.hw_reset_req_in (hw_reset_req),
		.cmd_start_in    (cmd_start),
		.cmd_bits_in     (cmd_bits),
		.cmd_ready_out   (cmd_ready),
		.resp_valid_out  (resp_valid),
		.resp_word_out   (resp_word),
		.rd_valid_out    (rd_valid),
		.rd_byte_out     (rd_byte)
	);

	hrs_device #(.POR_LOAD_CYC(100), .RST_SEQ_CYC(8)) i_hrs_device (
		.clock_in       (clock_in),
		.rstn_in        (rstn_in),
		.link           (link.dev),
		.hs400_mode_in  (hs400_mode),
		.rst_func_en_in (rst_func_en),
		.resp_start_in  (resp_start),
		.resp_bits_in   (resp_bits),
		.rd_start_in    (rd_start),
		.rd_len_in      (rd_len),
		.rd_data_in     (rd_data),
		.crc_start_in   (crc_start),
		.crc_tok_in     (crc_tok),
		.rd_take_out    (rd_take),
		.cmd_valid_out  (cmd_valid),
		.cmd_word_out   (cmd_word),
		.tx_busy_out    (tx_busy),
		.reset_busy_out (reset_busy),
		.reset_evt_out  (reset_evt),
		.rst_loaded_out (rst_loaded)
	);

	hrs_link_asserts i_hrs_link_asserts (
		.clock_in           (clock_in),
		.rstn_in            (rstn_in),
		.link_clk           (link.link_clk),
		.rst_line_n         (link.rst_line_n),
		.cmd_h_oe           (link.cmd_h_oe),
		.cmd_d_oe           (link.cmd_d_oe),
		.dat_d_oe           (link.dat_d_oe),
		.read_strobe_output (link.read_strobe_output),
		.hs400_mode_in      (hs400_mode),
		.rst_func_en_in     (rst_func_en)
	);

	// ----------------
	// Helpers
	// ----------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic logic [7:0] crc_exp(input logic [2:0] tk, input int i);
		logic [4:0] b;
		b = {1'b0, tk, 1'b1};
		return {7'h7f, b[4 - i]};
	endfunction

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("compared %0d mismatched %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic wait_on(ref logic s, input logic v, input int lim,
		output int n);
		n = 0;
		while (s !== v) begin
			@(negedge clock_in);
			n++;
			if (n > lim) begin
				miscompares++;
				$display("[ERR] %0t wait ran out", $time);
				report_and_stop();
			end
		end
	endtask

	// Pulse a start, feed read bytes until the transfer ends
	task automatic run_tx(ref logic start);
		int n;
		start = 1'b1;
		@(negedge clock_in);
		start = 1'b0;
		n = 0;
		while (tx_busy === 1'b1 && n < 800) begin
			if (rd_take === 1'b1 && idx < 4) begin
				idx++;
				rd_data = exp_b[idx];
			end
			@(negedge clock_in);
			n++;
		end
		check(48'(n < 800), 48'h1);
		repeat (8) @(negedge clock_in);
	endtask

	task automatic check_rd(input int n);
		check(48'(rd_q.size()), 48'(n));
		for (int i = 0; i < n && i < rd_q.size(); i++)
			check(48'(rd_q[i]), 48'(exp_b[i]));
		rd_q.delete();
	endtask

	initial begin
		clock_in = 1'b0;
		forever #25 clock_in = ~clock_in;
	end

	always @(posedge clock_in) begin
		stb_q <= link.read_strobe_output;
		if (link.read_strobe_output === 1'b1 && stb_q === 1'b0)
			n_stb++;
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_byte);
	end

	// ----------------
	// Sequence
	// ----------------
	initial begin
		rstn_in = 1'b0;
		{hw_reset_req, cmd_start, resp_start, rd_start, crc_start} = 5'h00;
		{hs400_mode, rst_func_en} = 2'h3;
		{cmd_bits, resp_bits} = 96'h0;
		{rd_len, rd_data, crc_tok} = 19'h00000;
		repeat (10) @(negedge clock_in);
		rstn_in = 1'b1;
		hw_reset_req = 1'b1;
		wait_on(link.rst_line_n, 1'b0, 60, k);
		hw_reset_req = 1'b0;
		wait_on(link.rst_line_n, 1'b1, 40, k);
		check(48'(rst_loaded), 48'h0);
		s0 = 0;
		repeat (150) begin
			@(negedge clock_in);
			if (reset_evt === 1'b1)
				s0 = 1;
		end
		check(48'(s0), 48'h0);
		check(48'(rst_loaded), 48'h1);
		$display("test power-on window done");
		wait_on(cmd_ready, 1'b1, 5000, k);
		hw_reset_req = 1'b1;
		wait_on(link.rst_line_n, 1'b0, 5, k);
		hw_reset_req = 1'b0;
		wait_on(link.rst_line_n, 1'b1, 40, k);
		check(48'(k), 48'h14);
		wait_on(reset_evt, 1'b1, 10, t);
		check(48'(t >= 3 && t <= 5), 48'h1);
		check(48'(reset_busy), 48'h1);
		wait_on(cmd_ready, 1'b1, 5000, k);
		t += k;
		for (int i = 0; i < 3; i++) begin
			rnd = lfsr_next(rnd);
			cmd_bits = {1'b0, rnd[14:0], rnd};
			wait_on(cmd_ready, 1'b1, 800, k);
			cmd_start = 1'b1;
			@(negedge clock_in);
			cmd_start = 1'b0;
			wait_on(link.cmd_h_oe, 1'b1, 20, k);
			if (i == 0)
				check(48'(t + k + 1 >= 4000), 48'h1);
			wait_on(cmd_valid, 1'b1, 800, k);
			check(cmd_word, cmd_bits);
		end
		$display("test reset and commands done");
		for (int m = 1; m >= 0; m--) begin
			hs400_mode = m[0];
			rnd = lfsr_next(rnd);
			resp_bits = {1'b0, rnd[14:0], rnd};
			s0 = n_stb;
			run_tx(resp_start);
			check(48'(m ? n_stb - s0 >= 48 : n_stb == s0), 48'h1);
			if (m == 1)
				check(resp_word, resp_bits);
		end
		hs400_mode = 1'b1;
		rd_q.delete();
		$display("test responses done");
		rnd = lfsr_next(rnd);
		rd_len = {6'h00, rnd[1:0]} + 8'h01;
		for (int i = 0; i < 4; i++)
			exp_b[i] = rnd[8 * i +: 8];
		idx = 0;
		rd_data = exp_b[0];
		run_tx(rd_start);
		check_rd(int'(rd_len));
		crc_tok = rnd[10:8];
		for (int i = 0; i < 5; i++)
			exp_b[i] = crc_exp(crc_tok, i);
		idx = 4;
		run_tx(crc_start);
		check_rd(5);
		s0 = n_stb;
		repeat (100) @(negedge clock_in);
		check(48'(n_stb - s0), 48'h0);
		$display("test read and crc done");
		report_and_stop();
	end
endmodule // test_hw_reset_and_strobe_control
